//--- hw/arc_map.vh
/*
 * Register map, field positions, codes and reset values of the ADC result computation block.
 * Assumes Avalon-MM word addressing: address index N is byte offset 4*N.
 */
`ifndef ARC_MAP_VH
`define ARC_MAP_VH

// ==========================================================
// Word addresses
`define ARC_A_FCTL     4'h0
`define ARC_A_TCTL     4'h1
`define ARC_A_CTRL     4'h2
`define ARC_A_STPT     4'h3
`define ARC_A_UTH      4'h4
`define ARC_A_LTH      4'h5
`define ARC_A_RES      4'h6
`define ARC_A_PREV     4'h7
`define ARC_A_ACC      4'h8
`define ARC_A_FILT     4'h9
`define ARC_A_ERR      4'hA
`define ARC_A_CNT      4'hB
`define ARC_A_IST      4'hC
`define ARC_A_ICLR     4'hD
`define ARC_A_IEN      4'hE

// ==========================================================
// Field positions
`define ARC_FC_PSIS    7
`define ARC_FC_CRS     6:4
`define ARC_FC_ACLR    3
`define ARC_FC_MODE    2:0
`define ARC_TC_CALC    6:4
`define ARC_TC_SOI     3
`define ARC_TC_TMD     2:0
`define ARC_CT_GO      0
`define ARC_CT_CONT    1
`define ARC_CT_DSEN    2
`define ARC_CNT_OVF    8
`define ARC_IS_THR     0
`define ARC_IS_DONE    1
`define ARC_IS_OVF     2

// ==========================================================
// Codes
`define ARC_MD_ACC     3'h1
`define ARC_MD_AVG     3'h2
`define ARC_MD_BURST   3'h3
`define ARC_MD_LPF     3'h4
`define ARC_CA_DIFF    3'h0
`define ARC_CA_RSTP    3'h1
`define ARC_CA_RFLT    3'h2
`define ARC_CA_PFLT    3'h4
`define ARC_CA_FSTP    3'h5
`define ARC_TM_OFF     3'h0
`define ARC_TM_BLO     3'h1
`define ARC_TM_GELO    3'h2
`define ARC_TM_IN      3'h3
`define ARC_TM_OUT     3'h4
`define ARC_TM_LEUP    3'h5
`define ARC_TM_GTUP    3'h6
`define ARC_TM_ALL     3'h7

// ==========================================================
// Reset values
`define ARC_R8         8'h00
`define ARC_R16        16'h0000
`define ARC_R18        18'h00000
`define ARC_R32        32'h00000000

`endif

//--- hw/arc_filter.v
/*
 * Accumulator, average and low-pass filter update for one computed sample.
 * Assumes the caller registers the outputs; purely combinational.
 */
`timescale 1ns/1ps
`include "arc_map.vh"

module arc_filter (
    input  wire [2:0]  mode_i,   // Computation mode
    input  wire [2:0]  crs_i,    // Shift control
    input  wire [15:0] smp_i,    // Sample, two's complement
    input  wire [17:0] acc_i,    // Accumulator now
    input  wire [7:0]  cnt_i,    // Sample count now
    input  wire [15:0] filt_i,   // Filtered value now
    output reg  [17:0] acc_o,    // Next accumulator
    output reg  [7:0]  cnt_o,    // Next count
    output reg  [15:0] filt_o,   // Next filtered value
    output reg         ovf_o,    // Accumulator overflowed
    output reg         done_o    // Average complete
);

    // ==========================================================
    // Division by a power of two, truncated toward zero
    function [18:0] div_tz;
        input [18:0] v;
        input [2:0]  sh;
        reg   [18:0] m;
        begin
            m = v[18] ? (~v + 19'h00001) : v;
            m = m >> sh;
            div_tz = v[18] ? (~m + 19'h00001) : m;
        end
    endfunction

    reg [18:0] a19;
    reg [18:0] s19;
    reg [18:0] sum;
    reg [18:0] q;
    reg [8:0]  cn;

    // ==========================================================
    // Update
    always @* begin
        a19 = {acc_i[17], acc_i};
        s19 = {{3{smp_i[15]}}, smp_i};
        cn = {1'b0, cnt_i} + 9'h001;
        sum = a19 + s19;
        acc_o = acc_i;
        cnt_o = cnt_i;
        filt_o = filt_i;
        ovf_o = 1'b0;
        done_o = 1'b0;
        case (mode_i)
            `ARC_MD_ACC, `ARC_MD_AVG, `ARC_MD_BURST: begin
                q = div_tz(sum, crs_i);
                acc_o = sum[17:0];
                ovf_o = sum[18] ^ sum[17];
                cnt_o = cn[8] ? cnt_i : cn[7:0];
                filt_o = q[15:0];
                if (mode_i != `ARC_MD_ACC && cn >= (9'h001 << crs_i)) begin
                    done_o = 1'b1;
                    acc_o = `ARC_R18;
                    cnt_o = 8'h00;
                end
            end
            `ARC_MD_LPF: begin
                sum = a19 - div_tz(a19, crs_i) + s19;
                q = div_tz(sum, crs_i);
                acc_o = sum[17:0];
                ovf_o = sum[18] ^ sum[17];
                cnt_o = cn[8] ? cnt_i : cn[7:0];
                filt_o = q[15:0];
                done_o = 1'b1;
            end
            default: begin
                q = sum;
            end
        endcase
    end

endmodule

//--- hw/arc_err_calc.v
/*
 * Error formula and threshold comparison for one calculation.
 * Assumes all values are 16-bit two's complement; purely combinational.
 */
`timescale 1ns/1ps
`include "arc_map.vh"

module arc_err_calc (
    input  wire [2:0]  calc_i,   // Error formula select
    input  wire [2:0]  tmd_i,    // Threshold mode
    input  wire        dsen_i,   // Double sample on
    input  wire [15:0] res_i,    // Current result
    input  wire [15:0] prev_i,   // Previous value
    input  wire [15:0] filt_i,   // Filtered value
    input  wire [15:0] stpt_i,   // Setpoint
    input  wire [15:0] uth_i,    // Upper threshold
    input  wire [15:0] lth_i,    // Lower threshold
    output reg  [15:0] err_o,    // Error value
    output reg         hit_o     // Threshold met
);

    reg [15:0] base;

    // ==========================================================
    // Formula and compare
    always @* begin
        base = dsen_i ? (res_i - prev_i) : res_i;
        case (calc_i)
            `ARC_CA_FSTP: err_o = filt_i - stpt_i;
            `ARC_CA_PFLT: err_o = prev_i - filt_i;
            `ARC_CA_RFLT: err_o = base - filt_i;
            `ARC_CA_RSTP: err_o = base - stpt_i;
            `ARC_CA_DIFF: err_o = res_i - prev_i;
            default:      err_o = `ARC_R16;
        endcase
        case (tmd_i)
            `ARC_TM_ALL:  hit_o = 1'b1;
            `ARC_TM_GTUP: hit_o = $signed(err_o) > $signed(uth_i);
            `ARC_TM_LEUP: hit_o = $signed(err_o) <= $signed(uth_i);
            `ARC_TM_OUT:  hit_o = $signed(err_o) < $signed(lth_i) ||
                                  $signed(err_o) > $signed(uth_i);
            `ARC_TM_IN:   hit_o = $signed(err_o) > $signed(lth_i) &&
                                  $signed(err_o) < $signed(uth_i);
            `ARC_TM_GELO: hit_o = $signed(err_o) >= $signed(lth_i);
            `ARC_TM_BLO:  hit_o = $signed(err_o) < $signed(lth_i);
            default:      hit_o = 1'b0;
        endcase
    end

endmodule

//--- hw/arc_top.v
/*
 * ADC result computation block: register file on Avalon-MM, conversion
 * sequencing, accumulate/average/filter, error and threshold interrupt.
 * Assumes the converter takes conv_start_o as a one-cycle request and later
 * returns one res_valid_i pulse with res_data_i, on the same clock.
 */
// Contract
// - Low-pass mode: time constant two to the shift value, unity gain.
// - Error formula chosen by bits 6 to 4; codes 111, 110, 011 reserved.
// - Code 101: error is filtered value minus setpoint.
// - Code 100: error is previous value minus filtered value.
// - Code 000: error is result minus previous value.
// - Double sample: codes 001, 010 use result minus previous as base.
// - Top bit of threshold control reads zero.
// - Previous select 0 loads prior result into previous value.
// - One conversion per trigger, or a pair when double sample set; burst mode repeats them until the average completes.
// - Continuous with stop-on-interrupt clears go on threshold, else retrigger.
// - Threshold mode field picks the condition that sets the flag.
`timescale 1ns/1ps
`include "arc_map.vh"

module arc_top (
    input  wire        clk_sys_i,          // System clock, 50 MHz
    input  wire        rst_i,              // Synchronous reset, high
    input  wire [3:0]  avs_address_i,      // Word address
    input  wire        avs_read_i,         // Read request
    input  wire        avs_write_i,        // Write request
    input  wire [31:0] avs_writedata_i,    // Write data
    input  wire [3:0]  avs_byteenable_i,   // Byte lanes
    output wire [31:0] avs_readdata_o,     // Read data
    output wire        avs_waitrequest_o,  // Stall
    output wire        conv_start_o,       // Start one conversion
    input  wire        res_valid_i,        // Result ready pulse
    input  wire [9:0]  res_data_i,         // Conversion result
    output wire        irq_o               // Interrupt, level
);

    // ==========================================================
    // States
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_START = 2'h1;
    localparam [1:0] ST_WAIT  = 2'h2;
    localparam [1:0] ST_CALC  = 2'h3;

    // ==========================================================
    // Declarations
    reg  [7:0]  fctl_q;
    reg  [6:0]  tctl_q;
    reg         go_q;
    reg         cont_q;
    reg         dsen_q;
    reg  [15:0] stpt_q;
    reg  [15:0] uth_q;
    reg  [15:0] lth_q;
    reg  [9:0]  res_q;
    reg  [15:0] prev_q;
    reg  [15:0] filt_q;
    reg  [15:0] err_q;
    reg  [17:0] acc_q;
    reg  [7:0]  cnt_q;
    reg         ovf_q;
    reg  [2:0]  ist_q;
    reg  [2:0]  ien_q;
    reg  [2:0]  ist_d;
    reg  [2:0]  iset;
    reg  [2:0]  iclr;
    reg         irq_q;
    reg         wait_q;
    reg  [31:0] rdata_q;
    reg  [31:0] rdata_d;
    reg         start_q;
    reg  [1:0]  state_q;
    reg         second_q;

    wire        req;
    wire        wr;
    wire [15:0] res16;
    wire [15:0] smp;
    wire [17:0] acc_n;
    wire [7:0]  cnt_n;
    wire [15:0] filt_n;
    wire        ovf_n;
    wire        avg_done;
    wire [15:0] err_n;
    wire        hit_n;
    wire        calc;

    // ==========================================================
    // Byte-lane merge for 16-bit registers
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] wd;
        input [3:0]  be;
        begin
            merge16[7:0] = be[0] ? wd[7:0] : old[7:0];
            merge16[15:8] = be[1] ? wd[15:8] : old[15:8];
        end
    endfunction

    // ==========================================================
    // Bus handshake
    assign req = avs_read_i | avs_write_i;
    assign wr = avs_write_i & ~wait_q;
    assign res16 = {6'h00, res_q};
    assign smp = dsen_q ? (res16 - prev_q) : res16;
    assign calc = (state_q == ST_CALC);

    assign avs_readdata_o = rdata_q;
    assign avs_waitrequest_o = wait_q;
    assign conv_start_o = start_q;
    assign irq_o = irq_q;

    // ==========================================================
    // Computation
    arc_filter u_filter (
        .mode_i (fctl_q[`ARC_FC_MODE]),
        .crs_i  (fctl_q[`ARC_FC_CRS]),
        .smp_i  (smp),
        .acc_i  (acc_q),
        .cnt_i  (cnt_q),
        .filt_i (filt_q),
        .acc_o  (acc_n),
        .cnt_o  (cnt_n),
        .filt_o (filt_n),
        .ovf_o  (ovf_n),
        .done_o (avg_done)
    );

    arc_err_calc u_err (
        .calc_i (tctl_q[`ARC_TC_CALC]),
        .tmd_i  (tctl_q[`ARC_TC_TMD]),
        .dsen_i (dsen_q),
        .res_i  (res16),
        .prev_i (prev_q),
        .filt_i (filt_n),
        .stpt_i (stpt_q),
        .uth_i  (uth_q),
        .lth_i  (lth_q),
        .err_o  (err_n),
        .hit_o  (hit_n)
    );

    // ==========================================================
    // Read mux
    always @* begin
        rdata_d = `ARC_R32;
        case (avs_address_i)
            `ARC_A_FCTL: rdata_d[7:0] = fctl_q;
            `ARC_A_TCTL: rdata_d[6:0] = tctl_q;
            `ARC_A_CTRL: rdata_d[2:0] = {dsen_q, cont_q, go_q};
            `ARC_A_STPT: rdata_d[15:0] = stpt_q;
            `ARC_A_UTH:  rdata_d[15:0] = uth_q;
            `ARC_A_LTH:  rdata_d[15:0] = lth_q;
            `ARC_A_RES:  rdata_d[9:0] = res_q;
            `ARC_A_PREV: rdata_d[15:0] = prev_q;
            `ARC_A_ACC:  rdata_d[17:0] = acc_q;
            `ARC_A_FILT: rdata_d[15:0] = filt_q;
            `ARC_A_ERR:  rdata_d[15:0] = err_q;
            `ARC_A_CNT:  rdata_d[8:0] = {ovf_q, cnt_q};
            `ARC_A_IST:  rdata_d[2:0] = ist_q;
            `ARC_A_IEN:  rdata_d[2:0] = ien_q;
            default:     rdata_d = `ARC_R32;
        endcase
    end

    // ==========================================================
    // Interrupt status: set wins over clear
    always @* begin
        iset = 3'h0;
        iclr = 3'h0;
        if (calc && !(fctl_q[`ARC_FC_MODE] == `ARC_MD_BURST && !avg_done)) begin
            iset[`ARC_IS_DONE] = 1'b1;
            iset[`ARC_IS_THR] = hit_n;
            iset[`ARC_IS_OVF] = ovf_n;
        end

        if (calc) begin
            iset[`ARC_IS_OVF] = ovf_n;
        end

        if (wr && avs_address_i == `ARC_A_ICLR && avs_byteenable_i[0]) begin
            iclr = avs_writedata_i[2:0];
        end

        ist_d = (ist_q & ~iclr) | iset;
    end

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            ist_q <= 3'h0;
            irq_q <= 1'b0;
        end else begin
            ist_q <= ist_d;
            irq_q <= |(ist_d & ien_q);
        end
    end

    // ==========================================================
    // Bus slave: one wait cycle, then the answer
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            wait_q <= 1'b1;
            rdata_q <= `ARC_R32;
        end else begin
            wait_q <= ~(req & wait_q);
            if (avs_read_i && wait_q) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // ==========================================================
    // Software registers
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            fctl_q <= `ARC_R8;
            tctl_q <= 7'h00;
            cont_q <= 1'b0;
            dsen_q <= 1'b0;
            stpt_q <= `ARC_R16;
            uth_q <= `ARC_R16;
            lth_q <= `ARC_R16;
            ien_q <= 3'h0;
        end else begin
            if (fctl_q[`ARC_FC_ACLR]) begin
                fctl_q[`ARC_FC_ACLR] <= 1'b0;
            end

            if (wr && avs_byteenable_i[0]) begin
                case (avs_address_i)
                    `ARC_A_FCTL: fctl_q <= avs_writedata_i[7:0];
                    `ARC_A_TCTL: tctl_q <= avs_writedata_i[6:0];
                    `ARC_A_CTRL: begin
                        cont_q <= avs_writedata_i[`ARC_CT_CONT];
                        dsen_q <= avs_writedata_i[`ARC_CT_DSEN];
                    end
                    `ARC_A_IEN:  ien_q <= avs_writedata_i[2:0];
                    default:     ien_q <= ien_q;
                endcase
            end

            if (wr) begin
                case (avs_address_i)
                    `ARC_A_STPT: stpt_q <= merge16(stpt_q, avs_writedata_i, avs_byteenable_i);
                    `ARC_A_UTH:  uth_q <= merge16(uth_q, avs_writedata_i, avs_byteenable_i);
                    `ARC_A_LTH:  lth_q <= merge16(lth_q, avs_writedata_i, avs_byteenable_i);
                    default:     lth_q <= lth_q;
                endcase
            end
        end
    end

    // ==========================================================
    // Conversion sequencer and datapath registers
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            go_q <= 1'b0;
            start_q <= 1'b0;
            second_q <= 1'b0;
            res_q <= 10'h000;
            prev_q <= `ARC_R16;
            filt_q <= `ARC_R16;
            err_q <= `ARC_R16;
            acc_q <= `ARC_R18;
            cnt_q <= 8'h00;
            ovf_q <= 1'b0;
        end else begin
            start_q <= 1'b0;

            case (state_q)
                ST_IDLE: begin
                    second_q <= 1'b0;
                    if (go_q) begin
                        state_q <= ST_START;
                    end
                end
                ST_START: begin
                    start_q <= 1'b1;
                    if (fctl_q[`ARC_FC_PSIS]) begin
                        prev_q <= filt_q;
                    end else begin
                        prev_q <= res16;
                    end
                    state_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (res_valid_i) begin
                        res_q <= res_data_i;
                        if (dsen_q && !second_q) begin
                            second_q <= 1'b1;
                            state_q <= ST_START;
                        end else begin
                            state_q <= ST_CALC;
                        end
                    end
                end
                ST_CALC: begin
                    second_q <= 1'b0;
                    acc_q <= acc_n;
                    cnt_q <= cnt_n;
                    filt_q <= filt_n;
                    ovf_q <= ovf_q | ovf_n;
                    err_q <= err_n;

                    if (fctl_q[`ARC_FC_MODE] == `ARC_MD_BURST && !avg_done) begin
                        state_q <= ST_START;
                    end else if (!go_q) begin
                        state_q <= ST_IDLE;
                    end else if (cont_q) begin
                        if (tctl_q[`ARC_TC_SOI] && hit_n) begin
                            go_q <= 1'b0;
                            state_q <= ST_IDLE;
                        end else begin
                            state_q <= ST_START;
                        end
                    end else begin
                        go_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase

            if (fctl_q[`ARC_FC_ACLR]) begin
                acc_q <= `ARC_R18;
                cnt_q <= 8'h00;
                ovf_q <= 1'b0;
            end

            if (wr && avs_byteenable_i[0] && avs_address_i == `ARC_A_CTRL) begin
                go_q <= avs_writedata_i[`ARC_CT_GO];
            end
        end
    end

endmodule

//--- verification/arc_conv_model.sv
/* Converter result path model.
   Assumes start_i is a one-cycle pulse on clk_i. */
`timescale 1ns/1ps
module arc_conv_model (
    input  wire logic       clk_i,   // Clock
    input  wire logic       start_i, // Start pulse
    input  wire logic [9:0] next_i,  // Next result
    input  wire logic [3:0] lat_i,   // Answer delay
    output logic            valid_o, // Result pulse
    output logic [9:0]      data_o   // Result
);
    int cnt = -1;
    logic [9:0] last = 10'h000;
    initial begin
        valid_o = 1'b0;
        data_o = 10'h3FF;
    end
    // Released lines show the inverse of the last result
    always @(posedge clk_i) begin
        valid_o <= 1'b0;
        data_o <= ~last;
        if (start_i) begin
            cnt <= int'(lat_i);
        end else if (cnt == 0) begin
            valid_o <= 1'b1;
            data_o <= next_i;
            last <= next_i;
            cnt <= -1;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule

//--- verification/arc_top_props.sv
/* Port checker for arc_top.
   Assumes it is bound to arc_top. */
`timescale 1ns/1ps
module arc_top_props (
    input wire logic        clk_sys_i,         // Clock
    input wire logic        rst_i,             // Reset
    input wire logic [3:0]  avs_address_i,     // Address
    input wire logic        avs_read_i,        // Read
    input wire logic        avs_write_i,       // Write
    input wire logic [31:0] avs_writedata_i,   // Write data
    input wire logic [31:0] avs_readdata_o,    // Read data
    input wire logic        avs_waitrequest_o, // Stall
    input wire logic        conv_start_o,      // Start
    input wire logic        irq_o              // Interrupt
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_go;
        avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h2 && avs_writedata_i[0];
    endsequence
    sequence s_mask;
        avs_write_i && !avs_waitrequest_o && avs_address_i == 4'hE
            && avs_writedata_i[2:0] == 3'h0;
    endsequence
    a_wait_answer: assert property (s_take |=> !avs_waitrequest_o)
        else $error("request not answered");
    a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer held too long");
    a_start_pulse: assert property (conv_start_o |=> !conv_start_o)
        else $error("start longer than one cycle");
    a_go_start: assert property (s_go |-> ##[1:3] conv_start_o)
        else $error("go gave no start");
    a_top_zero: assert property (s_take ##0 avs_read_i && avs_address_i == 4'h1
        |=> !avs_readdata_o[7])
        else $error("threshold top bit set");
    a_unmapped_zero: assert property (s_take ##0 avs_read_i && avs_address_i == 4'hF
        |=> avs_readdata_o == 32'h00000000)
        else $error("unmapped read not zero");
    a_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && avs_waitrequest_o
        && !conv_start_o)
        else $error("outputs busy after reset");
    a_irq_masked: assert property (s_mask |-> ##2 !irq_o [*3])
        else $error("irq while masked");
endmodule
bind arc_top arc_top_props chk_u (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .conv_start_o(conv_start_o), .irq_o(irq_o)
);

//--- verification/testbench.sv
/* Self-checking bench for arc_top.
   Assumes arc_map.vh on the include path. */
`timescale 1ns/1ps
`include "arc_map.vh"
module testbench;
    logic        clk_sys_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        av_r = 1'b0;
    logic        av_w = 1'b0;
    logic [3:0]  av_a = 4'h0;
    logic [31:0] av_d = 32'h0, q;
    logic [9:0]  nxt = 10'h0, last_r = 10'h0, prev_r = 10'h0;
    logic [3:0]  lat = 4'h0;
    logic [15:0] e, u, l, st;
    logic [2:0]  c, m;
    wire  [31:0] rdat;
    wire  [9:0]  rdt;
    wire         wreq, start, irq, rv;
    int fail_count = 0, check_count = 0, starts = 0, n0, i, s;
    always #10 clk_sys_i = ~clk_sys_i;
    arc_top dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(av_a),
        .avs_read_i(av_r), .avs_write_i(av_w), .avs_writedata_i(av_d),
        .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .conv_start_o(start), .res_valid_i(rv), .res_data_i(rdt), .irq_o(irq));
    arc_conv_model cnv_u (.clk_i(clk_sys_i), .start_i(start), .next_i(nxt),
        .lat_i(lat), .valid_o(rv), .data_o(rdt));
    always @(posedge clk_sys_i) begin
        if (start === 1'b1) starts <= starts + 1;
        if (rv === 1'b1) begin
            prev_r <= last_r;
            last_r <= rdt;
            nxt <= 10'($urandom);
            lat <= 4'($urandom % 8);
        end
    end
    // ==========================================================
    // Checking and bus tasks
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys_i);
        av_w <= w;
        av_r <= ~w;
        av_a <= a;
        av_d <= d;
        k = 0;
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (wreq !== 1'b0 && k < 20);
        if (wreq !== 1'b0) begin
            fail_count++;
            wrap_up;
        end
        q = rdat;
        av_w <= 1'b0;
        av_r <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d); acc(1'b1, a, d); endtask
    task automatic rd(input logic [3:0] a); acc(1'b0, a, 32'h0); endtask
    task automatic pause; repeat (4) @(posedge clk_sys_i); endtask
    task automatic run(input logic [2:0] ctl);
        int k;
        wr(`ARC_A_ICLR, 32'h7);
        wr(`ARC_A_CTRL, {29'h0, ctl});
        k = 0;
        q = 32'h0;
        while (q[1] !== 1'b1 && k < 60) begin
            rd(`ARC_A_IST);
            k++;
        end
        if (q[1] !== 1'b1) begin
            fail_count++;
            wrap_up;
        end
    endtask
    // ==========================================================
    // Expected values
    function automatic logic [15:0] experr(logic [2:0] cc, logic ds,
        logic [15:0] r, logic [15:0] p, logic [15:0] sp);
        logic [15:0] b;
        b = ds ? r - p : r;
        case (cc)
            3'h0: return r - p;
            3'h1: return b - sp;
            3'h2: return b;
            3'h4: return p;
            3'h5: return -sp;
            default: return 16'h0;
        endcase
    endfunction
    function automatic logic hit(logic [2:0] md, logic signed [15:0] ev,
        logic signed [15:0] up, logic signed [15:0] lo);
        case (md)
            3'h7: return 1'b1;
            3'h6: return ev > up;
            3'h5: return ev <= up;
            3'h4: return ev < lo || ev > up;
            3'h3: return ev > lo && ev < up;
            3'h2: return ev >= lo;
            3'h1: return ev < lo;
            default: return 1'b0;
        endcase
    endfunction
    // ==========================================================
    // Main sequence
    initial begin
        s = $urandom(32'h866C3184);
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        for (i = 0; i < 16; i++) begin
            rd(4'(i));
            chk(q, 32'h0);
        end
        wr(`ARC_A_TCTL, 32'hFF);
        rd(`ARC_A_TCTL);
        chk(q, 32'h7F);
        st = 16'($urandom % 512);
        u = 16'($urandom % 800) - 16'h190;
        l = u - 16'h12C;
        wr(`ARC_A_STPT, {16'h0, st});
        wr(`ARC_A_UTH, {16'h0, u});
        wr(`ARC_A_LTH, {16'h0, l});
        wr(`ARC_A_IEN, 32'h1);
        for (i = 0; i < 24; i++) begin
            c = 3'(i);
            m = 3'(i * 3);
            wr(`ARC_A_TCTL, {25'h0, c, 1'b0, m});
            n0 = starts;
            run({i >= 16, 2'b01});
            chk(32'(starts - n0), (i >= 16) ? 32'h2 : 32'h1);
            e = experr(c, i >= 16, {6'h0, last_r}, {6'h0, prev_r}, st);
            rd(`ARC_A_ERR);
            chk(q[15:0], e);
            rd(`ARC_A_IST);
            chk(q[0], hit(m, e, u, l));
            chk(irq, hit(m, e, u, l));
            rd(`ARC_A_PREV);
            chk(q[15:0], {6'h0, prev_r});
        end
        wr(`ARC_A_TCTL, 32'h07);
        run(3'b011);
        rd(`ARC_A_CTRL);
        chk(q[0], 1'b1);
        wr(`ARC_A_CTRL, 32'h0);
        repeat (3) pause;
        wr(`ARC_A_TCTL, 32'h0F);
        n0 = starts;
        run(3'b011);
        pause;
        rd(`ARC_A_CTRL);
        chk(q[0], 1'b0);
        chk(32'(starts - n0), 32'h1);
        chk(irq, 1'b1);
        wr(`ARC_A_IEN, 32'h0);
        pause;
        chk(irq, 1'b0);
        wr(`ARC_A_IEN, 32'h1);
        pause;
        chk(irq, 1'b1);
        wr(`ARC_A_ICLR, 32'h1);
        pause;
        chk(irq, 1'b0);
        wr(`ARC_A_TCTL, 32'h0);
        wr(`ARC_A_FCTL, 32'h04);
        run(3'b001);
        rd(`ARC_A_FILT);
        chk(q[15:0], {6'h0, last_r});
        wr(`ARC_A_FCTL, 32'h08);
        wr(`ARC_A_FCTL, 32'h21);
        s = 0;
        repeat (3) begin
            run(3'b001);
            s += int'(last_r);
        end
        rd(`ARC_A_ACC);
        chk(q[17:0], 18'(s));
        rd(`ARC_A_FILT);
        chk(q[15:0], 16'(s >> 2));
        wr(`ARC_A_FCTL, 32'h29);
        pause;
        rd(`ARC_A_FCTL);
        chk(q[7:0], 8'h21);
        rd(`ARC_A_ACC);
        chk(q, 32'h0);
        rd(`ARC_A_CNT);
        chk(q, 32'h0);
        wr(`ARC_A_FCTL, 32'h12);
        run(3'b001);
        s = int'(last_r);
        run(3'b001);
        s += int'(last_r);
        rd(`ARC_A_FILT);
        chk(q[15:0], 16'(s >> 1));
        rd(`ARC_A_ACC);
        chk(q, 32'h0);
        wr(`ARC_A_FCTL, 32'h13);
        run(3'b001);
        rd(`ARC_A_FILT);
        chk(q[15:0], (last_r + prev_r) >> 1);
        wrap_up;
    end
endmodule
